// [logic/epi_pkg.sv]
// Constants, register map and types for the external and pin-change interrupt unit.
// Contract
// - Sense field picks low, change, fall, rise.
// - External request needs global and own enable.
// - Pin sampled first; wider pulses always caught.
// - Bank one enable gates inputs 11 to 8.
// - Bank zero enable gates inputs 7 to 0.
// - Pin activity triggers even when pin drives.
// - Change on inputs 11 to 8 sets flag five.
// - Change on inputs 7 to 0 sets flag four.
// - External edge or change sets flag zero.
// - Flags clear on vector entry or written one.
// - Level sensing keeps external flag cleared.
// - Bank one mask bits enable single pins.
// - Bank zero mask bits enable single pins.
// - Reserved bits read zero, ignore writes.
// - Edge detection needs the running clock.
// - Pin-change detection works without the clock; the unit here sees no change while ce_i is low.
// - Low level requests while pin stays low.
package epi_pkg;

  // Register indices as printed; byte address is four times the index.
  localparam logic [7:0] EPI_IDX_MASK0   = 8'h09;
  localparam logic [7:0] EPI_IDX_FLAG    = 8'h0B;
  localparam logic [7:0] EPI_IDX_SENSE   = 8'h3A;
  localparam logic [7:0] EPI_IDX_ENABLE  = 8'h3B;
  localparam logic [7:0] EPI_IDX_MASK1   = 8'h0A;
  localparam logic [7:0] EPI_IDX_ISTAT   = 8'h40;
  localparam logic [7:0] EPI_IDX_IMASK   = 8'h41;

  // Writable bit masks per register.
  localparam logic [7:0] EPI_WMASK_SENSE  = 8'hDF;
  localparam logic [7:0] EPI_WMASK_ENABLE = 8'h31;
  localparam logic [7:0] EPI_WMASK_FLAG   = 8'h31;
  localparam logic [7:0] EPI_WMASK_MASK1  = 8'h0F;
  localparam logic [2:0] EPI_WMASK_EVT    = 3'h7;

  // Field positions.
  localparam int EPI_BIT_EXT   = 0;
  localparam int EPI_BIT_BANK0 = 4;
  localparam int EPI_BIT_BANK1 = 5;
  localparam int EPI_SENSE_LO  = 6;

  // Sense modes.
  localparam logic [1:0] EPI_SENSE_LOW    = 2'h0;
  localparam logic [1:0] EPI_SENSE_CHANGE = 2'h1;
  localparam logic [1:0] EPI_SENSE_FALL   = 2'h2;
  localparam logic [1:0] EPI_SENSE_RISE   = 2'h3;

  // Reset values.
  localparam logic [7:0]  EPI_RST_REG  = 8'h00;
  localparam logic [11:0] EPI_RST_PINS = 12'h000;
  localparam int          EPI_NPINS    = 12;

  // Bus slave states.
  typedef enum logic [1:0] {
    EPI_BUS_IDLE = 2'b01,
    EPI_BUS_ACK  = 2'b10
  } epi_bus_t;

endpackage : epi_pkg

// [logic/epi_unit.sv]
// External pin and pin-change interrupt unit with a classic Wishbone register slave.
`timescale 1ns/1ps
module epi_unit
  import epi_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Wishbone slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Pins and CPU side.
  input  wire logic        ext_irq0_i,
  input  wire logic [11:0] change_input_i,
  input  wire logic        global_irq_en_i,
  input  wire logic [2:0]  vector_taken_i,
  output logic      [2:0]  irq_request_o,
  output logic             irq_o
);

  // Register index map; the byte address on the bus is four times the index.
  // The mask for bank zero sits at index 0x09 and covers pins 7 to 0.
  // The mask for bank one sits at index 0x0A and covers pins 11 to 8 in its low nibble.
  // The flag register sits at index 0x0B; a one written to a flag clears it.
  // The sense register sits at index 0x3A; its top two bits pick the trigger.
  // The enable register sits at index 0x3B with the same bit layout as the flags.
  // The summary status sits at index 0x40 and clears when it is read.
  // The summary mask sits at index 0x41 and gates the single level interrupt.

  // Bus timing: a request is taken at the edge where cyc and stb are high and the
  // slave is idle; ack rises after that edge and stands for exactly one cycle.
  // Read data is registered at the taking edge, so it is valid while ack is high.
  // A master that still holds its request at the ack edge is not taken twice,
  // because the slave refuses a new request while its own ack is high.
  // Unmapped indices read as zero, ignore writes and are still acknowledged.

  // Pin timing: both pin groups are taken as synchronous inputs.
  // Each edge compares a pin with the sample from the edge before, so any level
  // that stands across one rising edge is seen; shorter glitches may be missed.
  // A flag rises at the edge after the pin changes, and its request rises with it.
  // Hazard: the first edge after reset compares against a zero sample, so a pin
  // that idles high looks like a rise; reset leaves the unit in low-level mode,
  // where no flag is kept, so that false edge does no harm.
  // Limitation: detection without a running clock is not modelled; while the clock
  // enable is low nothing is seen, and a change that outlasts it is caught later.

  typedef struct packed {
    epi_bus_t    bus;
    logic [31:0] rdata;
    logic        ack;
    logic [7:0]  sense;
    logic [7:0]  enable;
    logic [7:0]  flag;
    logic [7:0]  mask0;
    logic [7:0]  mask1;
    logic [2:0]  istat;
    logic [2:0]  imask;
    logic        ext_s;
    logic [11:0] pin_s;
    logic [2:0]  req;
    logic        irq;
  } epi_state_t;

  epi_state_t s_q;
  epi_state_t s_d;

  logic [7:0] idx;
  logic       hit;
  logic       wr;
  logic       rd;
  logic       ext_evt;
  logic       b0_evt;
  logic       b1_evt;
  logic       level_req;
  logic [7:0] wdat;
  logic [7:0] rmux;
  logic [11:0] pin_chg;
  logic [2:0] evt;

  assign idx  = wb_adr_i[9:2];
  assign wdat = wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00;
  assign hit  = wb_cyc_i && wb_stb_i && (s_q.bus == EPI_BUS_IDLE) && !s_q.ack;
  assign wr   = hit && wb_we_i && wb_sel_i[0];
  assign rd   = hit && !wb_we_i;

  // Pins are taken synchronous, so one register stage gives the prior sample for edges.
  genvar g;
  generate
    for (g = 0; g < EPI_NPINS; g++) begin : g_chg
      assign pin_chg[g] = change_input_i[g] ^ s_q.pin_s[g];
    end
  endgenerate

  // Pin-change events per bank; mask and bank enable gate each pin.
  assign b0_evt = s_q.enable[EPI_BIT_BANK0] && |(pin_chg[7:0] & s_q.mask0);
  assign b1_evt = s_q.enable[EPI_BIT_BANK1]
                  && |(pin_chg[11:8] & s_q.mask1[3:0]);

  // External pin edge decode on the sampled pin; works whatever the pin direction.
  always_comb begin
    ext_evt = 1'b0;
    case (s_q.sense[7:6])
      EPI_SENSE_CHANGE: ext_evt = ext_irq0_i ^ s_q.ext_s;
      EPI_SENSE_FALL:   ext_evt = s_q.ext_s && !ext_irq0_i;
      EPI_SENSE_RISE:   ext_evt = !s_q.ext_s && ext_irq0_i;
      default:          ext_evt = 1'b0;
    endcase
  end

  // Low level requests directly while the pin stays low; no flag is kept.
  assign level_req = (s_q.sense[7:6] == EPI_SENSE_LOW) && !ext_irq0_i;

  assign evt = {b1_evt, b0_evt, ext_evt};

  // Read mux; reserved bits are masked out on the way in, so they read zero.
  always_comb begin
    rmux = 8'h00;
    if (idx == EPI_IDX_MASK0) begin
      rmux = s_q.mask0;
    end else if (idx == EPI_IDX_MASK1) begin
      rmux = s_q.mask1;
    end else if (idx == EPI_IDX_FLAG) begin
      rmux = s_q.flag;
    end else if (idx == EPI_IDX_SENSE) begin
      rmux = s_q.sense;
    end else if (idx == EPI_IDX_ENABLE) begin
      rmux = s_q.enable;
    end else if (idx == EPI_IDX_ISTAT) begin
      rmux = {5'h00, s_q.istat};
    end else if (idx == EPI_IDX_IMASK) begin
      rmux = {5'h00, s_q.imask};
    end
  end

  // Next state: bus slave, registers, flags and requests.
  always_comb begin
    s_d = s_q;
    s_d.ext_s = ext_irq0_i;
    s_d.pin_s = change_input_i;
    s_d.ack   = hit;
    s_d.bus   = hit ? EPI_BUS_ACK : EPI_BUS_IDLE;
    if (rd) begin
      s_d.rdata = {24'h000000, rmux};
    end
    if (wr) begin
      if (idx == EPI_IDX_MASK0) begin
        s_d.mask0 = wdat;
      end else if (idx == EPI_IDX_MASK1) begin
        s_d.mask1 = wdat & EPI_WMASK_MASK1;
      end else if (idx == EPI_IDX_SENSE) begin
        s_d.sense = wdat & EPI_WMASK_SENSE;
      end else if (idx == EPI_IDX_ENABLE) begin
        s_d.enable = wdat & EPI_WMASK_ENABLE;
      end else if (idx == EPI_IDX_IMASK) begin
        s_d.imask = wdat[2:0] & EPI_WMASK_EVT;
      end
    end
    // Write-one and vector entry clear first; a fresh event then wins.
    if (wr && idx == EPI_IDX_FLAG) begin
      s_d.flag = s_q.flag & ~(wdat & EPI_WMASK_FLAG);
    end
    s_d.flag[EPI_BIT_EXT]   = s_d.flag[EPI_BIT_EXT] & ~vector_taken_i[0];
    s_d.flag[EPI_BIT_BANK0] = s_d.flag[EPI_BIT_BANK0] & ~vector_taken_i[1];
    s_d.flag[EPI_BIT_BANK1] = s_d.flag[EPI_BIT_BANK1] & ~vector_taken_i[2];
    s_d.flag[EPI_BIT_EXT]   = s_d.flag[EPI_BIT_EXT] | ext_evt;
    s_d.flag[EPI_BIT_BANK0] = s_d.flag[EPI_BIT_BANK0] | b0_evt;
    s_d.flag[EPI_BIT_BANK1] = s_d.flag[EPI_BIT_BANK1] | b1_evt;
    if (s_d.sense[7:6] == EPI_SENSE_LOW) begin
      s_d.flag[EPI_BIT_EXT] = 1'b0;
    end
    // Sticky status for the summary interrupt; read clears, event wins.
    if (rd && idx == EPI_IDX_ISTAT) begin
      s_d.istat = 3'h0;
    end
    s_d.istat = s_d.istat | evt;
    // Requests to the CPU vectoring.
    s_d.req[0] = global_irq_en_i && s_d.enable[EPI_BIT_EXT]
                 && (s_d.flag[EPI_BIT_EXT] || level_req);
    s_d.req[1] = global_irq_en_i && s_d.enable[EPI_BIT_BANK0]
                 && s_d.flag[EPI_BIT_BANK0];
    s_d.req[2] = global_irq_en_i && s_d.enable[EPI_BIT_BANK1]
                 && s_d.flag[EPI_BIT_BANK1];
    s_d.irq = |(s_d.istat & s_d.imask);
  end

  // State register; the enable freezes everything.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '{bus: EPI_BUS_IDLE, rdata: 32'h00000000, ack: 1'b0, sense: EPI_RST_REG,
               enable: EPI_RST_REG, flag: EPI_RST_REG, mask0: EPI_RST_REG,
               mask1: EPI_RST_REG, istat: 3'h0, imask: 3'h0, ext_s: 1'b0,
               pin_s: EPI_RST_PINS, req: 3'h0, irq: 1'b0};
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  assign wb_dat_o      = s_q.rdata;
  assign wb_ack_o      = s_q.ack;
  assign irq_request_o = s_q.req;
  assign irq_o         = s_q.irq;

  // Checks.

  // Level mode never keeps the external flag.
  chk_flag_low_mode: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_q.sense[7:6] == EPI_SENSE_LOW) |-> !s_q.flag[EPI_BIT_EXT])
    else $error("external flag set in level mode");

  // A sampled rise in rise mode sets the flag.
  chk_rise_sets_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && s_q.sense[7:6] == EPI_SENSE_RISE && !s_q.ext_s && ext_irq0_i
    |=> s_q.flag[EPI_BIT_EXT])
    else $error("rising edge did not set flag");

  // A sampled fall in fall mode sets the flag.
  chk_fall_sets_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && s_q.sense[7:6] == EPI_SENSE_FALL && s_q.ext_s && !ext_irq0_i
    |=> s_q.flag[EPI_BIT_EXT])
    else $error("falling edge did not set flag");

  // An unmasked change in bank zero is never lost.
  chk_bank0_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && b0_evt |=> s_q.flag[EPI_BIT_BANK0])
    else $error("bank zero change lost");

  // An unmasked change in bank one is never lost.
  chk_bank1_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && b1_evt |=> s_q.flag[EPI_BIT_BANK1])
    else $error("bank one change lost");

  // No request leaves while the global enable is low.
  chk_req_global: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !global_irq_en_i |=> s_q.req == 3'h0)
    else $error("request without global enable");

  // A held low level keeps requesting while enabled.
  chk_level_req: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && global_irq_en_i && s_q.enable[EPI_BIT_EXT] && level_req
    && s_q.sense == s_d.sense && s_q.enable == s_d.enable |=> s_q.req[0])
    else $error("level request missing");

  // A written one clears a flag when no fresh event competes.
  chk_w1c_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && wr && idx == EPI_IDX_FLAG && wdat[EPI_BIT_BANK0] && !b0_evt
    |=> !s_q.flag[EPI_BIT_BANK0])
    else $error("write one did not clear flag");

  // Reserved enable and mask bits stay zero.
  chk_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_q.enable & ~EPI_WMASK_ENABLE) == 8'h00 && s_q.mask1[7:4] == 4'h0)
    else $error("reserved bits set");

  // Ack is a single-cycle pulse.
  chk_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && s_q.ack |=> !s_q.ack)
    else $error("ack held two cycles");

  // Any sampled change in change mode sets the flag, unless the mode is rewritten.
  chk_change_sets_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && s_q.sense[7:6] == EPI_SENSE_CHANGE && (ext_irq0_i != s_q.ext_s)
    && !(wr && idx == EPI_IDX_SENSE) |=> s_q.flag[EPI_BIT_EXT])
    else $error("pin change did not set flag");

  // Fall mode ignores rises; only a sampled fall may raise the flag.
  chk_fall_only: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && s_q.sense[7:6] == EPI_SENSE_FALL && !s_q.flag[EPI_BIT_EXT]
    && !(s_q.ext_s && !ext_irq0_i) |=> !s_q.flag[EPI_BIT_EXT])
    else $error("flag set without falling edge");

  // Rise mode ignores falls; only a sampled rise may raise the flag.
  chk_rise_only: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && s_q.sense[7:6] == EPI_SENSE_RISE && !s_q.flag[EPI_BIT_EXT]
    && !(!s_q.ext_s && ext_irq0_i) |=> !s_q.flag[EPI_BIT_EXT])
    else $error("flag set without rising edge");

  // The external request needs its own enable bit.
  chk_ext_needs_enable: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !s_d.enable[EPI_BIT_EXT] |=> !s_q.req[0])
    else $error("external request while disabled");

  // The bank one request needs its bank enable.
  chk_bank1_needs_enable: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !s_d.enable[EPI_BIT_BANK1] |=> !s_q.req[2])
    else $error("bank one request while disabled");

  // The bank zero request needs its bank enable.
  chk_bank0_needs_enable: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !s_d.enable[EPI_BIT_BANK0] |=> !s_q.req[1])
    else $error("bank zero request while disabled");

  // The bank zero request is the product of flag, enable and global enable.
  chk_bank0_req_level: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i |=> s_q.req[1] == ($past(global_irq_en_i) && s_q.enable[EPI_BIT_BANK0]
    && s_q.flag[EPI_BIT_BANK0]))
    else $error("bank zero request level wrong");

  // The bank one request is the product of flag, enable and global enable.
  chk_bank1_req_level: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i |=> s_q.req[2] == ($past(global_irq_en_i) && s_q.enable[EPI_BIT_BANK1]
    && s_q.flag[EPI_BIT_BANK1]))
    else $error("bank one request level wrong");

  // Masked pins of bank one never raise its flag.
  chk_mask1_blocks: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !s_q.flag[EPI_BIT_BANK1] && (pin_chg[11:8] & s_q.mask1[3:0]) == 4'h0
    |=> !s_q.flag[EPI_BIT_BANK1])
    else $error("masked bank one pin set flag");

  // Masked pins of bank zero never raise its flag.
  chk_mask0_blocks: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !s_q.flag[EPI_BIT_BANK0] && (pin_chg[7:0] & s_q.mask0) == 8'h00
    |=> !s_q.flag[EPI_BIT_BANK0])
    else $error("masked bank zero pin set flag");

  // Entering the external vector clears its flag when no event competes.
  chk_vec_clears_ext: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && vector_taken_i[0] && !ext_evt |=> !s_q.flag[EPI_BIT_EXT])
    else $error("vector entry kept external flag");

  // Entering the bank one vector clears its flag when no event competes.
  chk_vec_clears_bank1: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && vector_taken_i[2] && !b1_evt |=> !s_q.flag[EPI_BIT_BANK1])
    else $error("vector entry kept bank one flag");

  // A written zero leaves a set flag alone.
  chk_zero_write_keeps: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && wr && idx == EPI_IDX_FLAG && !wdat[EPI_BIT_BANK0]
    && s_q.flag[EPI_BIT_BANK0] && !vector_taken_i[1] |=> s_q.flag[EPI_BIT_BANK0])
    else $error("zero write cleared flag");

  // Reserved flag bits and the spare sense bit stay zero.
  chk_flag_reserved: assert property (@(posedge clk_i) disable iff (rst_i)
    s_q.flag[7:6] == 2'h0 && s_q.flag[3:1] == 3'h0 && s_q.sense[5] == 1'b0)
    else $error("reserved flag or sense bit set");

  // A high pin in level mode gives no external request.
  chk_level_quiet_high: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && s_q.sense[7:6] == EPI_SENSE_LOW && s_d.sense[7:6] == EPI_SENSE_LOW
    && ext_irq0_i |=> !s_q.req[0])
    else $error("level request with pin high");

  // Switching into level mode drops the external flag at once.
  chk_low_clears_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && s_d.sense[7:6] == EPI_SENSE_LOW |=> !s_q.flag[EPI_BIT_EXT])
    else $error("flag survived switch to level mode");

  // Every taken request is acknowledged on the next edge.
  chk_ack_after_take: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && hit |=> s_q.ack)
    else $error("taken request not acknowledged");

  // Registers are eight bits wide, so the upper read data stays zero.
  chk_rdata_upper: assert property (@(posedge clk_i) disable iff (rst_i)
    s_q.rdata[31:8] == 24'h000000)
    else $error("upper read data not zero");

  // Events reach the sticky status even during a clearing read.
  chk_istat_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && evt != 3'h0 |=> (s_q.istat & $past(evt)) == $past(evt))
    else $error("event missing from status");

  // The level interrupt follows unmasked status bits.
  chk_irq_summary: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i |=> s_q.irq == |(s_q.istat & s_q.imask))
    else $error("summary interrupt wrong");

  // A low clock enable freezes every bit of state.
  chk_freeze_state: assert property (@(posedge clk_i) disable iff (rst_i)
    !ce_i |=> $stable(s_q))
    else $error("state moved while frozen");

endmodule : epi_unit

// [verif/epi_pins_model.sv]
// Pin-side model driving the external interrupt pin and the pin-change inputs.
`timescale 1ns/1ps
module epi_pins_model (
  // Clock.
  input  wire logic        clk_i,
  // Pins towards the unit.
  output logic             ext_irq0_o,
  output logic      [11:0] change_input_o
);
  // The external line idles high so that low-level mode stays quiet after reset.
  initial begin
    ext_irq0_o = 1'b1;
    change_input_o = 12'h000;
  end

  // Every change is held for two edges, so no pulse is too short to be sampled.
  task automatic set_ext(input logic v);
    @(posedge clk_i);
    ext_irq0_o <= v;
    repeat (2) @(posedge clk_i);
  endtask : set_ext

  // Toggle one change input and hold the new level.
  task automatic toggle(input int i);
    @(posedge clk_i);
    change_input_o[i] <= ~change_input_o[i];
    repeat (2) @(posedge clk_i);
  endtask : toggle
endmodule : epi_pins_model

// [verif/epi_unit_tb.sv]
// Self-checking testbench for the external and pin-change interrupt unit.
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
  $display("Error at %0t: got %0h expected %0h", $time, g, e); end end
module epi_unit_tb;
  import epi_pkg::*;
  logic        clk_i, rst_i, cyc, stb, we, gie, ack, irq, ext, ce;
  logic [3:0]  sel;
  logic [31:0] adr, wdat, rdat;
  logic [2:0]  vec, req;
  logic [11:0] chg;
  logic [7:0]  rd;
  int          err_total, n_tests;

  // Unit under test and the pin model; clock enable and byte select are driven by tests.
  epi_unit dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .ext_irq0_i(ext), .change_input_i(chg), .global_irq_en_i(gie),
    .vector_taken_i(vec), .irq_request_o(req), .irq_o(irq));
  epi_pins_model pins_u (.clk_i(clk_i), .ext_irq0_o(ext), .change_input_o(chg));

  // One classic cycle; the request is held until ack is seen at an edge.
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {22'h000000, idx, 2'h0};
    wdat <= {24'h000000, d};
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (k >= 50) err_total++;
    rd = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : bus

  // Pulse a vector-entry line, then let the clearing edge land.
  task automatic vt(input logic [2:0] b);
    @(posedge clk_i);
    vec <= b;
    @(posedge clk_i);
    vec <= 3'h0;
    @(posedge clk_i);
  endtask : vt

  task automatic t_regs;
    logic [7:0] ix [5] = '{EPI_IDX_MASK0, EPI_IDX_FLAG, EPI_IDX_SENSE, EPI_IDX_ENABLE,
                           EPI_IDX_MASK1};
    foreach (ix[i]) begin
      bus(1'b0, ix[i], 8'h00);
      `CHK(rd, 8'h00)
    end
    bus(1'b1, EPI_IDX_ENABLE, 8'hFF);
    bus(1'b0, EPI_IDX_ENABLE, 8'h00);
    `CHK(rd, 8'h31)
    bus(1'b1, EPI_IDX_MASK1, 8'hFF);
    bus(1'b0, EPI_IDX_MASK1, 8'h00);
    `CHK(rd, 8'h0F)
    bus(1'b1, EPI_IDX_SENSE, 8'hFF);
    bus(1'b0, EPI_IDX_SENSE, 8'h00);
    `CHK(rd, 8'hDF)
    bus(1'b1, 8'h20, 8'hFF);
    bus(1'b0, 8'h20, 8'h00);
    `CHK(rd, 8'h00)
    $display("t_regs done");
  endtask : t_regs

  task automatic t_ext;
    logic [1:0] m;
    logic       f;
    bus(1'b1, EPI_IDX_ENABLE, 8'h01);
    for (int i = 1; i < 4; i++) begin
      m = 2'(i);
      bus(1'b1, EPI_IDX_SENSE, {m, 6'h00});
      bus(1'b1, EPI_IDX_FLAG, 8'h31);
      for (int e = 0; e < 2; e++) begin
        pins_u.set_ext(1'(e));
        f = (m == 2'h1) || (m == {1'b1, 1'(e)});
        `CHK(req[0], f)
        bus(1'b0, EPI_IDX_FLAG, 8'h00);
        `CHK(rd[0], f)
        bus(1'b1, EPI_IDX_FLAG, 8'h01);
        bus(1'b0, EPI_IDX_FLAG, 8'h00);
        `CHK(rd[0], 1'b0)
      end
    end
    $display("t_ext done");
  endtask : t_ext

  task automatic t_level;
    bus(1'b1, EPI_IDX_SENSE, 8'h00);
    pins_u.set_ext(1'b0);
    `CHK(req[0], 1'b1)
    bus(1'b0, EPI_IDX_FLAG, 8'h00);
    `CHK(rd[0], 1'b0)
    @(posedge clk_i);
    gie <= 1'b0;
    repeat (2) @(posedge clk_i);
    `CHK(req[0], 1'b0)
    gie <= 1'b1;
    pins_u.set_ext(1'b1);
    `CHK(req[0], 1'b0)
    $display("t_level done");
  endtask : t_level

  task automatic t_chg;
    logic [2:0] b;
    bus(1'b1, EPI_IDX_ENABLE, 8'h30);
    bus(1'b1, EPI_IDX_MASK0, 8'hFF);
    bus(1'b1, EPI_IDX_FLAG, 8'h31);
    for (int i = 0; i < 12; i++) begin
      b = (i < 8) ? 3'h2 : 3'h4;
      pins_u.toggle(i);
      `CHK(req, b)
      bus(1'b0, EPI_IDX_FLAG, 8'h00);
      `CHK(rd, (i < 8) ? 8'h10 : 8'h20)
      vt(b);
      `CHK(req, 3'h0)
    end
    bus(1'b1, EPI_IDX_ENABLE, 8'h20);
    pins_u.toggle(2);
    `CHK(req, 3'h0)
    bus(1'b1, EPI_IDX_ENABLE, 8'h30);
    bus(1'b1, EPI_IDX_FLAG, 8'h31);
    bus(1'b1, EPI_IDX_MASK0, 8'h00);
    bus(1'b1, EPI_IDX_MASK1, 8'h00);
    pins_u.toggle(3);
    pins_u.toggle(9);
    bus(1'b0, EPI_IDX_FLAG, 8'h00);
    `CHK(rd, 8'h00)
    $display("t_chg done");
  endtask : t_chg

  task automatic t_stat;
    bus(1'b1, EPI_IDX_MASK0, 8'h01);
    bus(1'b1, EPI_IDX_MASK1, 8'h01);
    bus(1'b0, EPI_IDX_ISTAT, 8'h00);
    bus(1'b1, EPI_IDX_IMASK, 8'h02);
    pins_u.toggle(8);
    `CHK(irq, 1'b0)
    pins_u.toggle(0);
    `CHK(irq, 1'b1)
    bus(1'b0, EPI_IDX_ISTAT, 8'h00);
    `CHK(rd, 8'h06)
    repeat (2) @(posedge clk_i);
    `CHK(irq, 1'b0)
    $display("t_stat done");
  endtask : t_stat

  // Clock enable low freezes the unit; a byte select of zero blocks a write.
  task automatic t_ce;
    bus(1'b1, EPI_IDX_FLAG, 8'h31);
    @(posedge clk_i);
    ce <= 1'b0;
    pins_u.toggle(0);
    `CHK(req, 3'h0)
    ce <= 1'b1;
    repeat (2) @(posedge clk_i);
    `CHK(req, 3'h2)
    sel <= 4'h0;
    bus(1'b1, EPI_IDX_MASK0, 8'hFF);
    sel <= 4'h1;
    bus(1'b0, EPI_IDX_MASK0, 8'h00);
    `CHK(rd, 8'h01)
    $display("t_ce done");
  endtask : t_ce

  task automatic conclude;
    $display("Checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  // Free-running 200 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // Main sequence; reset is held for six edges before any request.
  initial begin
    {rst_i, cyc, stb, we, gie, ce} = 6'h21;
    {adr, wdat, vec, err_total, n_tests} = '0;
    sel = 4'h1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    gie <= 1'b1;
    t_regs;
    t_ext;
    t_level;
    t_chg;
    t_stat;
    t_ce;
    conclude;
  end

  // Watchdog, far beyond the few hundred cycles the tests need.
  initial begin
    #100000;
    err_total++;
    conclude;
  end
endmodule : epi_unit_tb
